// ---- dv/itfl_input_decode_bench.sv ----
`timescale 1ns/10ps
`include "itfl_defines.svh"
module itfl_input_decode_bench;
  import itfl_pkg::*;
  ////////////////////////////////////////
  // inputs driven by the bench, all set at time zero
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  itfl_cfg_type term_cfg = '0;
  itfl_src_type operation_source_setting = ITFL_SRC_KEYPAD;
  logic [1:0]   direction_restriction_setting = 2'h0;
  logic         ramp_time_set_setting = 1'b0;
  logic         motor_stopped = 1'b1;
  logic         speed_locked = 1'b0;
  logic         param_write_req = 1'b0;
  // contacts and outputs
  wire  [3:0]   term_in;
  itfl_ctl_type ctl;
  logic         output_enable, speed_search, restart_zero;
  logic         freq_up_step, freq_down_step;
  logic         param_write_ok, param_write_reject;
  logic [15:0]  event_count;
  int           failures = 0;
  int           n_checks = 0;
  // 250 MHz
  always #2 mclk = ~mclk;
  itfl_sw i_itfl_sw (
    .mclk    (mclk),
    .term_in (term_in)
  );
  itfl_input_decode i_itfl_input_decode (
    .mclk                          (mclk),
    .rst_b                         (rst_b),
    .term_in                       (term_in),
    .term_cfg                      (term_cfg),
    .operation_source_setting      (operation_source_setting),
    .direction_restriction_setting (direction_restriction_setting),
    .ramp_time_set_setting         (ramp_time_set_setting),
    .motor_stopped                 (motor_stopped),
    .speed_locked                  (speed_locked),
    .param_write_req               (param_write_req),
    .ctl                           (ctl),
    .output_enable                 (output_enable),
    .speed_search                  (speed_search),
    .restart_zero                  (restart_zero),
    .freq_up_step                  (freq_up_step),
    .freq_down_step                (freq_down_step),
    .param_write_ok                (param_write_ok),
    .param_write_reject            (param_write_reject),
    .event_count                   (event_count)
  );
  ////////////////////////////////////////
  // n edges, landing 1 ns after the last so updates have settled
  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // level codes on terminal three, code 0 inert
  task automatic t_levels;
    logic [4:0] code [8] = '{5'h06, 5'h07, 5'h0e, 5'h0f, 5'h11, 5'h16,
                             5'h00, 5'h15};
    logic [15:0] want [8] = '{16'h200, 16'h100, 16'h020, 16'h010, 16'h008,
                              16'h001, 16'h000, 16'h006};
    for (int i = 0; i < 8; i++) begin
      term_cfg = {15'h0000, code[i]};
      i_itfl_sw.put(4'h1);
      step;
      chk({6'h00, ctl[11:2]}, want[i]);
      i_itfl_sw.put(4'h0);
      step;
      // a code 21 terminal keeps the override up with its contact open
      chk({6'h00, ctl[11:2]}, {14'h0, code[i] == 5'h15, 1'b0});
    end
    // a restricted direction setting ignores the contact
    direction_restriction_setting = 2'h1;
    i_itfl_sw.put(4'h1);
    step;
    chk({15'h0, ctl.dir_override}, 16'h0000);
    i_itfl_sw.put(4'h0);
    direction_restriction_setting = 2'h0;
    // the stored ramp set choice reaches the core with no contact
    ramp_time_set_setting = 1'b1;
    step;
    chk({15'h0, ctl.ramp_set_two}, 16'h0001);
    ramp_time_set_setting = 1'b0;
  endtask
  task automatic t_lock;
    term_cfg = {15'h0000, 5'h11};
    param_write_req = 1'b1;
    step;
    chk({14'h0, param_write_ok, param_write_reject}, 16'h2);
    i_itfl_sw.put(4'h1);
    step;
    chk({14'h0, param_write_ok, param_write_reject}, 16'h1);
    // lock held a further cycle while the write is still pending
    step;
    chk({14'h0, param_write_ok, param_write_reject}, 16'h1);
    i_itfl_sw.put(4'h0);
    param_write_req = 1'b0;
  endtask
  // every mix of the three source overrides
  task automatic t_source;
    itfl_src_type want;
    term_cfg = {5'h00, 5'h14, 5'h13, 5'h12};
    operation_source_setting = ITFL_SRC_OTHER;
    for (int p = 0; p < 8; p++) begin
      i_itfl_sw.put(p[3:0]);
      step;
      want = p[0] ? ITFL_SRC_TERMINAL : p[1] ? ITFL_SRC_KEYPAD :
             p[2] ? ITFL_SRC_COMM : ITFL_SRC_OTHER;
      chk(16'(ctl.run_source), 16'(want));
    end
    i_itfl_sw.put(4'h0);
  endtask
  // block then search, then shutoff on and off
  task automatic t_block;
    term_cfg = {10'h000, 5'h10, 5'h09};
    i_itfl_sw.put(4'h1);
    #1 chk({15'h0, output_enable}, 16'h0000);
    step;
    chk({15'h0, ctl.output_block}, 16'h0001);
    i_itfl_sw.put(4'h0);
    step(3);
    chk({15'h0, speed_search}, 16'h0001);
    speed_locked = 1'b1;
    step(2);
    chk({14'h0, speed_search, output_enable}, 16'h0001);
    speed_locked = 1'b0;
    i_itfl_sw.put(4'h2);
    #1 chk({15'h0, output_enable}, 16'h0000);
    step;
    chk({15'h0, restart_zero}, 16'h0001);
    i_itfl_sw.put(4'h0);
    step;
    chk({14'h0, restart_zero, speed_search}, 16'h0002);
    step;
    chk({15'h0, output_enable}, 16'h0001);
  endtask
  task automatic t_count;
    term_cfg = {10'h000, 5'h0d, 5'h0c};
    i_itfl_sw.tap(0, 4);
    i_itfl_sw.tap(0, 1);
    i_itfl_sw.tap(0, 1);
    chk(event_count, 16'h0003);
    i_itfl_sw.put(4'h3);
    step(2);
    chk(event_count, 16'h0000);
    i_itfl_sw.put(4'h1);
    step(2);
    chk(event_count, 16'h0000);
    i_itfl_sw.put(4'h0);
    step;
    i_itfl_sw.tap(0, 1);
    chk(event_count, 16'h0001);
  endtask
  // held raise repeats; both held stops all steps
  task automatic t_updown;
    int n;
    n = 0;
    term_cfg = {10'h000, 5'h0b, 5'h0a};
    i_itfl_sw.put(4'h1);
    repeat (2 * `ITFL_REPEAT_CYC) begin
      step;
      n += (freq_up_step === 1'b1);
    end
    chk(n[15:0], 16'h0002);
    n = 0;
    i_itfl_sw.put(4'h3);
    repeat (600) begin
      step;
      n += (freq_up_step === 1'b1) + (freq_down_step === 1'b1);
    end
    chk(n[15:0], 16'h0000);
    i_itfl_sw.put(4'h0);
    step;
    i_itfl_sw.put(4'h2);
    step;
    chk({15'h0, freq_down_step}, 16'h0001);
    i_itfl_sw.put(4'h0);
  endtask
  // jog code taken only while the motor stands
  task automatic t_jog;
    motor_stopped = 1'b0;
    term_cfg = {15'h0000, 5'h08};
    i_itfl_sw.put(4'h1);
    step(2);
    chk({15'h0, ctl.jog}, 16'h0000);
    motor_stopped = 1'b1;
    step(2);
    chk({15'h0, ctl.jog}, 16'h0001);
  endtask
  initial begin
    step(5);
    rst_b = 1'b1;
    step;
    t_levels;
    t_lock;
    t_source;
    t_block;
    t_count;
    t_updown;
    t_jog;
    close_out;
  end
  // hang guard: counts as a mismatch
  initial begin
    #100us;
    failures++;
    close_out;
  end
endmodule // itfl_input_decode_bench

// ---- dv/itfl_props_properties.sv ----
`timescale 1ns/10ps
////////////////////////////////////////
// pin-level checks on the decoder; each ties an output to its cause
module itfl_props (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_b,
  // contacts, settings, write attempt
  input wire logic [3:0]             term_in,
  input wire itfl_pkg::itfl_cfg_type term_cfg,
  input wire logic                   param_write_req,
  // outputs under watch
  input wire logic                   output_enable,
  input wire logic                   speed_search,
  input wire logic                   restart_zero,
  input wire logic                   freq_up_step,
  input wire logic                   freq_down_step,
  input wire logic                   param_write_ok,
  input wire logic                   param_write_reject,
  input wire logic [15:0]            event_count
);
  import itfl_pkg::*;
  // high when a closed contact carries function code k
  function automatic logic hit(input itfl_cfg_type c,
                               input logic [3:0] t, input logic [4:0] k);
    hit = |(t & {c.code_six == k, c.code_five == k,
                 c.code_four == k, c.code_three == k});
  endfunction
  // decoded contact functions
  wire logic w_blk = hit(term_cfg, term_in, 5'h09);
  wire logic w_up  = hit(term_cfg, term_in, 5'h0a);
  wire logic w_dn  = hit(term_cfg, term_in, 5'h0b);
  wire logic w_trg = hit(term_cfg, term_in, 5'h0c);
  wire logic w_clr = hit(term_cfg, term_in, 5'h0d);
  wire logic w_off = hit(term_cfg, term_in, 5'h10);
  wire logic w_lck = hit(term_cfg, term_in, 5'h11);
  ////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // edges are only judged once the previous sample was out of reset
  sequence s_rel; $past(rst_b) && $fell(w_blk) && !w_off; endsequence
  sequence s_up; $past(rst_b) && $rose(w_up) && !w_dn; endsequence
  property p_blk; w_blk |-> !output_enable; endproperty
  a_blk: assert property (p_blk) else $error("drive on in block");
  property p_rel; s_rel |=> speed_search; endproperty
  a_rel: assert property (p_rel) else $error("no search");
  property p_up; s_up |=> freq_up_step; endproperty
  a_up: assert property (p_up) else $error("no up step");
  property p_both; w_up && w_dn |=> !freq_up_step && !freq_down_step;
  endproperty
  a_both: assert property (p_both) else $error("step while both");
  property p_cnt; $past(rst_b) && $rose(w_trg) && !w_clr
    |=> event_count == $past(event_count) + 16'h0001; endproperty
  a_cnt: assert property (p_cnt) else $error("count off");
  property p_clr; w_clr |=> event_count == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("count not held");
  property p_zero; $past(rst_b) && $changed(w_off) |=> restart_zero;
  endproperty
  a_zero: assert property (p_zero) else $error("no restart");
  property p_lck; $past(rst_b) && $past(w_lck) && param_write_req
    |-> param_write_reject && !param_write_ok; endproperty
  a_lck: assert property (p_lck) else $error("write let in");
endmodule // itfl_props

bind itfl_input_decode itfl_props i_itfl_props (
  .mclk               (mclk),
  .rst_b              (rst_b),
  .term_in            (term_in),
  .term_cfg           (term_cfg),
  .param_write_req    (param_write_req),
  .output_enable      (output_enable),
  .speed_search       (speed_search),
  .restart_zero       (restart_zero),
  .freq_up_step       (freq_up_step),
  .freq_down_step     (freq_down_step),
  .param_write_ok     (param_write_ok),
  .param_write_reject (param_write_reject),
  .event_count        (event_count)
);

// ---- dv/itfl_sw.sv ----
`timescale 1ns/10ps
// switch contacts on terminals three..six, closed = high
module itfl_sw (
  // clock of the controller working the switches
  input  wire logic mclk,
  // contact levels
  output logic [3:0] term_in
);
  // all contacts open at power up
  initial term_in = 4'h0;
  // set all contacts; called just after an edge
  task automatic put(input logic [3:0] v);
    term_in = v;
  endtask
  // close contact k for hi cycles, then one open cycle
  task automatic tap(input int k, input int hi);
    term_in[k] = 1'b1;
    repeat (hi) @(posedge mclk);
    #1 term_in[k] = 1'b0;
    @(posedge mclk);
    #1;
  endtask
endmodule // itfl_sw

// ---- include/itfl_defines.svh ----
`ifndef ITFL_DEFINES_SVH
`define ITFL_DEFINES_SVH

// function codes held by each terminal's 5-bit setting
`define ITFL_CODE_W        5
`define ITFL_FN_NONE       5'h00
`define ITFL_FN_RAMP_HOLD  5'h06
`define ITFL_FN_RAMP_SEL   5'h07
`define ITFL_FN_JOG        5'h08
`define ITFL_FN_BLOCK      5'h09
`define ITFL_FN_UP         5'h0a
`define ITFL_FN_DOWN       5'h0b
`define ITFL_FN_CNT_TRIG   5'h0c
`define ITFL_FN_CNT_CLR    5'h0d
`define ITFL_FN_EXT_FAULT  5'h0e
`define ITFL_FN_LOOP_OFF   5'h0f
`define ITFL_FN_SHUTOFF    5'h10
`define ITFL_FN_PARAM_LOCK 5'h11
`define ITFL_FN_SRC_TERM   5'h12
`define ITFL_FN_SRC_KEY    5'h13
`define ITFL_FN_SRC_COMM   5'h14
`define ITFL_FN_DIR        5'h15
`define ITFL_FN_FREQ2      5'h16

// number of terminals and widths
`define ITFL_NUM_TERM      4
`define ITFL_CNT_W         16
`define ITFL_SRC_W         2

// reset values
`define ITFL_CNT_RST       16'h0000
`define ITFL_DIR_RESTRICT_NONE 2'h0

// step repeat while up/down held: time in ns and derived cycle count
`define ITFL_REPEAT_NS     2000
`define ITFL_CLK_NS        4
`define ITFL_REPEAT_CYC    (`ITFL_REPEAT_NS / `ITFL_CLK_NS)
`define ITFL_RPT_W         10

`endif

// ---- include/itfl_pkg.sv ----
package itfl_pkg;

  // run command sources, encoded as the operation-source setting
  typedef enum logic [1:0] {
    ITFL_SRC_KEYPAD = 2'h0,
    ITFL_SRC_TERMINAL = 2'h1,
    ITFL_SRC_COMM = 2'h2,
    ITFL_SRC_OTHER = 2'h3
  } itfl_src_type;

  // terminal settings: one function code per terminal three..six
  typedef struct packed {
    logic [4:0] code_six;
    logic [4:0] code_five;
    logic [4:0] code_four;
    logic [4:0] code_three;
  } itfl_cfg_type;

  // decoded commands to the drive core
  typedef struct packed {
    logic         ramp_hold;
    logic         ramp_set_two;
    logic         jog;
    logic         output_block;
    logic         ext_fault;
    logic         loop_disable;
    logic         param_lock;
    logic         dir_reverse;
    logic         dir_override;
    logic         freq_second;
    itfl_src_type run_source;
  } itfl_ctl_type;

  // output stage sequencing
  typedef enum logic [1:0] {
    ITFL_ST_RUN,
    ITFL_ST_BLOCKED,
    ITFL_ST_SEARCH,
    ITFL_ST_SHUTOFF
  } itfl_state_type;

endpackage

// ---- verilog/itfl_input_decode.sv ----
`timescale 1ns/10ps
`include "itfl_defines.svh"

module itfl_input_decode (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  // terminal contacts, bit 0 = terminal three
  input  wire logic [3:0]                term_in,
  // terminal function settings
  input  wire itfl_pkg::itfl_cfg_type    term_cfg,
  input  wire itfl_pkg::itfl_src_type    operation_source_setting,
  input  wire logic [1:0]                direction_restriction_setting,
  input  wire logic                      ramp_time_set_setting,
  // drive core status
  input  wire logic                      motor_stopped,
  input  wire logic                      speed_locked,
  input  wire logic                      param_write_req,
  // drive core commands
  output itfl_pkg::itfl_ctl_type         ctl,
  output logic                           output_enable,
  output logic                           speed_search,
  output logic                           restart_zero,
  output logic                           freq_up_step,
  output logic                           freq_down_step,
  output logic                           param_write_ok,
  output logic                           param_write_reject,
  output logic [15:0]                    event_count
);
  import itfl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // per-code activity of the terminals

  // true when any terminal holding code fn is on
  function automatic logic any_on(input logic [4:0] fn,
                                  input itfl_cfg_type cfg,
                                  input logic [3:0] pins);
    logic hit;
    hit = 1'b0;
    hit = hit | (pins[0] & (cfg.code_three == fn));
    hit = hit | (pins[1] & (cfg.code_four == fn));
    hit = hit | (pins[2] & (cfg.code_five == fn));
    hit = hit | (pins[3] & (cfg.code_six == fn));
    return hit;
  endfunction

  logic [4:0] jog_code_reg;   // jog-filtered copy of terminal settings
  logic [4:0] jog_code_next;
  logic       up_on;          // raise held
  logic       down_on;        // lower held
  logic       trig_on;        // count trigger level
  logic       clr_on;         // counter clear level
  logic       block_on;       // output block level
  logic       shut_on;        // output shutoff level
  logic       jog_on;         // jog level

  // code 0 never matches anything below, so unused terminals stay inert
  // zero means no effect
  always_comb begin
    up_on    = any_on(`ITFL_FN_UP, term_cfg, term_in);
    down_on  = any_on(`ITFL_FN_DOWN, term_cfg, term_in);
    trig_on  = any_on(`ITFL_FN_CNT_TRIG, term_cfg, term_in);
    clr_on   = any_on(`ITFL_FN_CNT_CLR, term_cfg, term_in);
    block_on = any_on(`ITFL_FN_BLOCK, term_cfg, term_in);
    shut_on  = any_on(`ITFL_FN_SHUTOFF, term_cfg, term_in);
    jog_on   = 1'b0;
    for (int i = 0; i < `ITFL_NUM_TERM; i++) begin
      if (jog_code_reg[i] && term_in[i]) begin
        jog_on = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // jog assignment latch

  // a jog assignment made while running is held off until stop
  always_comb begin
    jog_code_next = jog_code_reg;
    if (motor_stopped) begin
      jog_code_next[0] = (term_cfg.code_three == `ITFL_FN_JOG);
      jog_code_next[1] = (term_cfg.code_four == `ITFL_FN_JOG);
      jog_code_next[2] = (term_cfg.code_five == `ITFL_FN_JOG);
      jog_code_next[3] = (term_cfg.code_six == `ITFL_FN_JOG);
    end
    jog_code_next[4] = 1'b0;  // spare bit, held low
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      jog_code_reg <= 5'h00;
    end else begin
      jog_code_reg <= jog_code_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge detect, repeat timer and event counter

  logic                   up_d_reg, up_d_next;     // previous raise level
  logic                   dn_d_reg, dn_d_next;     // previous lower level
  logic                   trig_d_reg, trig_d_next; // previous trigger level
  logic [`ITFL_RPT_W-1:0] rpt_reg, rpt_next;       // repeat spacing count
  logic                   up_step_reg, up_step_next;
  logic                   dn_step_reg, dn_step_next;
  logic [15:0]            cnt_reg, cnt_next;
  logic                   step_ok;                 // exactly one of up/down

  always_comb begin
    up_d_next    = up_on;
    dn_d_next    = down_on;
    trig_d_next  = trig_on;
    up_step_next = 1'b0;
    dn_step_next = 1'b0;
    rpt_next     = rpt_reg;
    cnt_next     = cnt_reg;
    step_ok      = up_on ^ down_on;
    if (!step_ok) begin
      rpt_next = '0;
    end else if ((up_on && !up_d_reg) || (down_on && !dn_d_reg)) begin
      up_step_next = up_on;
      dn_step_next = down_on;
      rpt_next     = '0;
    end else if (rpt_reg == `ITFL_RPT_W'(`ITFL_REPEAT_CYC - 1)) begin
      up_step_next = up_on;
      dn_step_next = down_on;
      rpt_next     = '0;
    end else begin
      rpt_next = rpt_reg + `ITFL_RPT_W'(1);
    end
    if (clr_on) begin
      cnt_next = `ITFL_CNT_RST;
    end else if (trig_on && !trig_d_reg) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      up_d_reg    <= 1'b0;
      dn_d_reg    <= 1'b0;
      trig_d_reg  <= 1'b0;
      rpt_reg     <= '0;
      up_step_reg <= 1'b0;
      dn_step_reg <= 1'b0;
      cnt_reg     <= `ITFL_CNT_RST;
    end else begin
      up_d_reg    <= up_d_next;
      dn_d_reg    <= dn_d_next;
      trig_d_reg  <= trig_d_next;
      rpt_reg     <= rpt_next;
      up_step_reg <= up_step_next;
      dn_step_reg <= dn_step_next;
      cnt_reg     <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output stage sequencing: block, search, shutoff

  itfl_state_type st_reg, st_next;
  logic           shut_d_reg, shut_d_next;   // previous shutoff level
  logic           zero_reg, zero_next;       // restart-from-zero pulse

  // shutoff outranks base block: both coast, but shutoff restarts at zero
  always_comb begin
    st_next     = st_reg;
    shut_d_next = shut_on;
    zero_next   = shut_on ^ shut_d_reg;
    unique case (st_reg)
      ITFL_ST_RUN: begin
        if (shut_on) st_next = ITFL_ST_SHUTOFF;
        else if (block_on) st_next = ITFL_ST_BLOCKED;
      end
      ITFL_ST_BLOCKED: begin
        if (shut_on) st_next = ITFL_ST_SHUTOFF;
        else if (!block_on) st_next = ITFL_ST_SEARCH;
      end
      ITFL_ST_SEARCH: begin
        if (shut_on) st_next = ITFL_ST_SHUTOFF;
        else if (block_on) st_next = ITFL_ST_BLOCKED;
        else if (speed_locked) st_next = ITFL_ST_RUN;
      end
      ITFL_ST_SHUTOFF: begin
        // restart is from zero, so no speed search needed
        if (!shut_on) begin
          st_next = block_on ? ITFL_ST_BLOCKED : ITFL_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg     <= ITFL_ST_RUN;
      shut_d_reg <= 1'b0;
      zero_reg   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      shut_d_reg <= shut_d_next;
      zero_reg   <= zero_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // level commands and run source, registered

  itfl_ctl_type ctl_reg, ctl_next;

  always_comb begin
    ctl_next = '0;
    ctl_next.ramp_hold    = any_on(`ITFL_FN_RAMP_HOLD, term_cfg, term_in);
    ctl_next.ramp_set_two = ramp_time_set_setting
                          | any_on(`ITFL_FN_RAMP_SEL, term_cfg, term_in);
    ctl_next.jog          = jog_on;
    ctl_next.output_block = block_on | shut_on;
    ctl_next.ext_fault    = any_on(`ITFL_FN_EXT_FAULT, term_cfg, term_in);
    ctl_next.loop_disable = any_on(`ITFL_FN_LOOP_OFF, term_cfg, term_in);
    ctl_next.param_lock   = any_on(`ITFL_FN_PARAM_LOCK, term_cfg, term_in);
    ctl_next.dir_override = (direction_restriction_setting ==
                             `ITFL_DIR_RESTRICT_NONE) &&
                            (term_cfg.code_three == `ITFL_FN_DIR ||
                             term_cfg.code_four == `ITFL_FN_DIR ||
                             term_cfg.code_five == `ITFL_FN_DIR ||
                             term_cfg.code_six == `ITFL_FN_DIR);
    ctl_next.dir_reverse  = ctl_next.dir_override
                          & any_on(`ITFL_FN_DIR, term_cfg, term_in);
    ctl_next.freq_second  = any_on(`ITFL_FN_FREQ2, term_cfg, term_in);
    if (any_on(`ITFL_FN_SRC_TERM, term_cfg, term_in)) begin
      ctl_next.run_source = ITFL_SRC_TERMINAL;
    end else if (any_on(`ITFL_FN_SRC_KEY, term_cfg, term_in)) begin
      ctl_next.run_source = ITFL_SRC_KEYPAD;
    end else if (any_on(`ITFL_FN_SRC_COMM, term_cfg, term_in)) begin
      ctl_next.run_source = ITFL_SRC_COMM;
    end else begin
      ctl_next.run_source = operation_source_setting;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign ctl            = ctl_reg;
  // blocking is combinational so the bridge drops on the same cycle
  assign output_enable  = (st_reg == ITFL_ST_RUN ||
                           st_reg == ITFL_ST_SEARCH) && !block_on && !shut_on;
  assign speed_search   = (st_reg == ITFL_ST_SEARCH);
  assign restart_zero   = zero_reg;
  assign freq_up_step   = up_step_reg;
  assign freq_down_step = dn_step_reg;
  assign param_write_ok     = param_write_req && !ctl_reg.param_lock;
  assign param_write_reject = param_write_req && ctl_reg.param_lock;
  assign event_count    = cnt_reg;

endmodule // itfl_input_decode
